// >>> pct_map.svh
// register offsets, field positions and timing counts of the position compare block
// assumes inclusion by bare name from every file that needs a number
`ifndef PCT_MAP_SVH
`define PCT_MAP_SVH

// ==========================================================================
// address decode
`define PCT_ADDR_W        8
`define PCT_GLOBAL_BIT    7
`define PCT_AXIS_BIT      6
`define PCT_REG_MODE      6'h00
`define PCT_REG_CNT       6'h04
`define PCT_REG_DATA      6'h08
`define PCT_REG_STS       6'h0c
`define PCT_REG_TSIZE     6'h10
`define PCT_REG_TADDR     6'h14
`define PCT_REG_TWDATA    6'h18
`define PCT_REG_FACTOR    6'h1c
`define PCT_REG_INTSTS    6'h20
`define PCT_REG_INTAXIS   8'h80

// ==========================================================================
// mode fields and codes
`define PCT_MODE_W        7
`define PCT_REL_GT        2'h0
`define PCT_REL_EQ        2'h1
`define PCT_REL_LT        2'h2
`define PCT_SRC_C1        2'h0
`define PCT_SRC_C2        2'h1
`define PCT_SRC_BOTH      2'h2

// ==========================================================================
// status fields
`define PCT_STS_COND      0
`define PCT_STS_ARMED     1
`define PCT_STS_PULSE     2
`define PCT_STS_DONE      3
`define PCT_STS_IDX_LSB   16

// ==========================================================================
// table and interrupt sizes
`define PCT_TBL_DEPTH     1024
`define PCT_TBL_AW        10
`define PCT_TSIZE_W       11
`define PCT_NEXT_CAUSE    12
`define PCT_NCAUSE        13
`define PCT_CAUSE_CMP     12

// ==========================================================================
// timing
`define PCT_CLK_MHZ       25
`define PCT_PULSE_US      100
`define PCT_PULSE_CYC     (`PCT_PULSE_US * `PCT_CLK_MHZ)
`define PCT_PULSE_W       12

`endif

// >>> pct_pkg.sv
// types shared by the position compare block
// assumes pct_map.svh is compiled alongside
`include "pct_map.svh"

package pct_pkg;

	// mode register layout, msb first
	typedef struct packed {
		logic       tbl_en;
		logic       int_en;
		logic       home_clr;
		logic [1:0] src;
		logic [1:0] rel;
	} pct_mode_type;

	// per-axis inputs from the field side
	typedef struct packed {
		logic                         encoder_phase_a;
		logic                         encoder_phase_b;
		logic                         home_done;
		logic [`PCT_NEXT_CAUSE-1:0]   cause;
	} pct_axis_in_type;

	typedef enum logic [1:0] {
		PCT_ST_IDLE,
		PCT_ST_FETCH,
		PCT_ST_LOAD,
		PCT_ST_ARMED
	} pct_cmp_state_type;

endpackage

// >>> pct_table_mem.sv
// compare table storage: one write port, one registered read port
// assumes a single clock; read data appear one edge after the address
`include "pct_map.svh"
`timescale 1ns/1ns
`default_nettype none

module pct_table_mem (
	// clock
	input  wire logic                    pclk,
	// write port
	input  wire logic                    we,
	input  wire logic [`PCT_TBL_AW-1:0]  waddr,
	input  wire logic [31:0]             wdata,
	// read port
	input  wire logic [`PCT_TBL_AW-1:0]  raddr,
	output var  logic [31:0]             rdata
);

	logic [31:0] mem [`PCT_TBL_DEPTH];

	always_ff @(posedge pclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge pclk) begin
		rdata <= mem[raddr];
	end

endmodule
`default_nettype wire

// >>> pct_top.sv
// two-axis position compare trigger with interrupt gathering, APB slave
// assumes all field inputs are synchronous to pclk
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`include "pct_map.svh"
`timescale 1ns/1ns
`default_nettype none

module pct_top (
	// clock and reset
	input  wire logic                              pclk,
	input  wire logic                              presetn,
	// apb slave
	input  wire logic                              psel,
	input  wire logic                              penable,
	input  wire logic                              pwrite,
	input  wire logic [`PCT_ADDR_W-1:0]            paddr,
	input  wire logic [31:0]                       pwdata,
	output var  logic [31:0]                       prdata,
	output logic                                   pready,
	output logic                                   pslverr,
	// field side
	input  wire pct_pkg::pct_axis_in_type [1:0]    axis_in,
	output var  logic [1:0]                        trig_out,
	output logic                                   irq_out
);

	// ======================================================================
	// bus decode
	logic                        glob_sel;
	logic                        ax_sel;
	logic [5:0]                  reg_off;
	logic                        mapped;
	logic                        acc;
	logic                        wr_acc;
	logic                        rd_acc;
	logic                        setup;
	logic [31:0]                 rd_mux;

	logic signed [31:0]          cnt_w   [2];
	logic [31:0]                 rdv_w   [2];
	logic [`PCT_NCAUSE-1:0]      pend_w  [2];

	assign glob_sel = paddr[`PCT_GLOBAL_BIT];
	assign ax_sel   = paddr[`PCT_AXIS_BIT];
	assign reg_off  = paddr[5:0];
	assign mapped   = glob_sel ? (paddr == `PCT_REG_INTAXIS) : (reg_off <= `PCT_REG_INTSTS && reg_off[1:0] == 2'h0);
	assign setup    = psel & ~penable;
	assign acc      = psel & penable;
	assign wr_acc   = acc & pwrite & mapped;
	assign rd_acc   = acc & ~pwrite & mapped;
	assign pready   = 1'b1;
	assign pslverr  = acc & ~mapped;

	always_comb begin
		if (!mapped) begin
			rd_mux = 32'h0000_0000;
		end else if (glob_sel) begin
			rd_mux = {30'h0000_0000, |pend_w[1], |pend_w[0]};
		end else begin
			rd_mux = rdv_w[ax_sel];
		end
	end

	// read data captured in the setup cycle, presented through the access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup && !pwrite) begin
			prdata <= rd_mux;
		end
	end

	assign irq_out = (|pend_w[0]) | (|pend_w[1]);

	// ======================================================================
	// per-axis comparator
	genvar ax;
	generate
		for (ax = 0; ax < 2; ax++) begin : g_axis
			logic                              wsel;
			pct_pkg::pct_mode_type             mode_r;
			logic signed [31:0]                cnt_r;
			logic signed [31:0]                data_r;
			logic signed [31:0]                cmp_r;
			logic [`PCT_TSIZE_W-1:0]           tsize_r;
			logic [`PCT_TBL_AW-1:0]            taddr_r;
			logic [`PCT_TBL_AW-1:0]            idx_r;
			logic                              done_r;
			logic [`PCT_NEXT_CAUSE-1:0]        factor_r;
			logic [`PCT_NCAUSE-1:0]            pend_r;
			logic [`PCT_NCAUSE-1:0]            pend_set;
			pct_pkg::pct_cmp_state_type        st_r;
			logic                              a_prev_r;
			logic                              b_prev_r;
			logic                              q_step;
			logic                              q_up;
			logic [`PCT_PULSE_W-1:0]           pw_r;
			logic                              rel1;
			logic                              rel2;
			logic                              cond;
			logic                              hit;
			logic                              last;
			logic [31:0]                       mem_rdata;
			logic signed [31:0]                other;
			logic                              trig_r;

			assign wsel  = wr_acc & ~glob_sel & (ax_sel == 1'(ax));
			assign other = cnt_w[1-ax];

			// ------------------------------------------------------------------
			// configuration registers
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					mode_r   <= '0;
					data_r   <= 32'h0000_0000;
					tsize_r  <= '0;
					factor_r <= '0;
				end else if (wsel) begin
					case (reg_off)
						`PCT_REG_MODE:   mode_r   <= pct_pkg::pct_mode_type'(pwdata[`PCT_MODE_W-1:0]);
						`PCT_REG_DATA:   data_r   <= pwdata;
						`PCT_REG_TSIZE:  tsize_r  <= pwdata[`PCT_TSIZE_W-1:0];
						`PCT_REG_FACTOR: factor_r <= pwdata[`PCT_NEXT_CAUSE-1:0];
						default: begin
						end
					endcase
				end
			end

			// table write address auto-increments per data word
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					taddr_r <= '0;
				end else if (wsel && reg_off == `PCT_REG_TADDR) begin
					taddr_r <= pwdata[`PCT_TBL_AW-1:0];
				end else if (wsel && reg_off == `PCT_REG_TWDATA) begin
					taddr_r <= taddr_r + 1'b1;
				end
			end

			pct_table_mem u_mem (
				.pclk  (pclk),
				.we    (wsel && reg_off == `PCT_REG_TWDATA),
				.waddr (taddr_r),
				.wdata (pwdata),
				.raddr (idx_r),
				.rdata (mem_rdata)
			);

			// ------------------------------------------------------------------
			// quadrature counter
			assign q_step = a_prev_r ^ axis_in[ax].encoder_phase_a ^ b_prev_r ^ axis_in[ax].encoder_phase_b;
			assign q_up   = axis_in[ax].encoder_phase_a ^ b_prev_r;

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					a_prev_r <= 1'b0;
					b_prev_r <= 1'b0;
				end else begin
					a_prev_r <= axis_in[ax].encoder_phase_a;
					b_prev_r <= axis_in[ax].encoder_phase_b;
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cnt_r <= 32'sh0000_0000;
				end else if (mode_r.home_clr && axis_in[ax].home_done) begin
					cnt_r <= 32'sh0000_0000;
				end else if (wsel && reg_off == `PCT_REG_CNT) begin
					cnt_r <= pwdata;
				end else if (q_step) begin
					cnt_r <= q_up ? cnt_r + 32'sh1 : cnt_r - 32'sh1;
				end
			end
			assign cnt_w[ax] = cnt_r;

			// ------------------------------------------------------------------
			// relation and match
			always_comb begin
				case (mode_r.rel)
					`PCT_REL_GT: begin
						rel1 = cnt_r > cmp_r;
						rel2 = other > cmp_r;
					end
					`PCT_REL_EQ: begin
						rel1 = cnt_r == cmp_r;
						rel2 = other == cmp_r;
					end
					`PCT_REL_LT: begin
						rel1 = cnt_r < cmp_r;
						rel2 = other < cmp_r;
					end
					default: begin
						rel1 = 1'b0;
						rel2 = 1'b0;
					end
				endcase
				case (mode_r.src)
					`PCT_SRC_C2:   cond = rel2;
					`PCT_SRC_BOTH: cond = rel1 & rel2;
					default:       cond = rel1;
				endcase
			end

			assign hit  = (st_r == pct_pkg::PCT_ST_ARMED) && cond && (pw_r == '0);
			assign last = ({1'b0, idx_r} + 1'b1) >= tsize_r;

			// ------------------------------------------------------------------
			// compare sequencer
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					st_r   <= pct_pkg::PCT_ST_IDLE;
					idx_r  <= '0;
					cmp_r  <= 32'sh0000_0000;
					done_r <= 1'b0;
				end else if (wsel && reg_off == `PCT_REG_MODE) begin
					idx_r  <= '0;
					done_r <= 1'b0;
					st_r   <= pwdata[`PCT_MODE_W-1] ? pct_pkg::PCT_ST_FETCH : pct_pkg::PCT_ST_IDLE;
				end else if (wsel && reg_off == `PCT_REG_DATA && !mode_r.tbl_en) begin
					cmp_r  <= pwdata; // re-arms once per written value
					done_r <= 1'b0;
					st_r   <= pct_pkg::PCT_ST_ARMED;
				end else begin
					case (st_r)
						pct_pkg::PCT_ST_FETCH: begin
							if (tsize_r == '0) begin
								done_r <= 1'b1;
								st_r   <= pct_pkg::PCT_ST_IDLE;
							end else begin
								st_r <= pct_pkg::PCT_ST_LOAD;
							end
						end
						pct_pkg::PCT_ST_LOAD: begin
							cmp_r <= mem_rdata;
							st_r  <= pct_pkg::PCT_ST_ARMED;
						end
						pct_pkg::PCT_ST_ARMED: begin
							if (hit) begin
								if (mode_r.tbl_en && !last) begin
									idx_r <= idx_r + 1'b1;
									st_r  <= pct_pkg::PCT_ST_FETCH;
								end else begin
									done_r <= 1'b1;
									st_r   <= pct_pkg::PCT_ST_IDLE;
								end
							end
						end
						default: st_r <= pct_pkg::PCT_ST_IDLE;
					endcase
				end
			end

			// ------------------------------------------------------------------
			// trigger pulse
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pw_r <= '0;
				end else if (hit) begin
					pw_r <= `PCT_PULSE_W'(`PCT_PULSE_CYC);
				end else if (pw_r != '0) begin
					pw_r <= pw_r - 1'b1;
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					trig_r <= 1'b0;
				end else begin
					trig_r <= hit | (pw_r > `PCT_PULSE_W'(1));
				end
			end
			assign trig_out[ax] = trig_r;

			// ------------------------------------------------------------------
			// interrupt causes, cleared only for bits reported by the read
			assign pend_set = {hit & mode_r.int_en, axis_in[ax].cause & factor_r};

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pend_r <= '0;
				end else if (rd_acc && !glob_sel && ax_sel == 1'(ax) && reg_off == `PCT_REG_INTSTS) begin
					pend_r <= (pend_r & ~prdata[`PCT_NCAUSE-1:0]) | pend_set;
				end else begin
					pend_r <= pend_r | pend_set;
				end
			end
			assign pend_w[ax] = pend_r;

			// ------------------------------------------------------------------
			// read view
			always_comb begin
				case (reg_off)
					`PCT_REG_MODE:   rdv_w[ax] = {25'h000_0000, mode_r};
					`PCT_REG_CNT:    rdv_w[ax] = cnt_r;
					`PCT_REG_DATA:   rdv_w[ax] = data_r;
					`PCT_REG_STS:    rdv_w[ax] = {6'h00, idx_r, 12'h000, done_r, pw_r != '0,
					                              st_r == pct_pkg::PCT_ST_ARMED, cond};
					`PCT_REG_TSIZE:  rdv_w[ax] = {21'h00_0000, tsize_r};
					`PCT_REG_TADDR:  rdv_w[ax] = {22'h00_0000, taddr_r};
					`PCT_REG_FACTOR: rdv_w[ax] = {20'h0_0000, factor_r};
					`PCT_REG_INTSTS: rdv_w[ax] = {19'h0_0000, pend_r};
					default:         rdv_w[ax] = 32'h0000_0000;
				endcase
			end
		end
	endgenerate

endmodule
`default_nettype wire

// >>> pct_enc_model.sv
// quadrature encoder model for the phase inputs of one axis
// assumes single-cycle step requests synchronous to pclk
`timescale 1ns/1ns
`default_nettype none

module pct_enc_model (
	// clock
	input  wire logic pclk,
	// step requests
	input  wire logic up,
	input  wire logic dn,
	// encoder phases
	output logic      ea,
	output logic      eb
);
	bit [1:0] ph_r;

	// ==========================================================
	// one phase edge per request, a leads b when stepping up
	always @(posedge pclk) begin
		if (up)
			ph_r <= ph_r + 2'h1;
		else if (dn)
			ph_r <= ph_r - 2'h1;
	end
	assign ea = ph_r[0] ^ ph_r[1];
	assign eb = ph_r[1];
endmodule

`default_nettype wire

// >>> pct_top_properties.sv
// concurrent checks on the ports of the position compare block
// assumes binding to pct_top and a single pclk domain
`include "pct_map.svh"
`timescale 1ns/1ns
`default_nettype none

module pct_top_properties (
	// clock and reset
	input wire logic                           pclk,
	input wire logic                           presetn,
	// apb
	input wire logic                           psel,
	input wire logic                           penable,
	input wire logic                           pwrite,
	input wire logic [`PCT_ADDR_W-1:0]         paddr,
	input wire logic [31:0]                    pwdata,
	input wire logic [31:0]                    prdata,
	input wire logic                           pready,
	input wire logic                           pslverr,
	// field side
	input wire pct_pkg::pct_axis_in_type [1:0] axis_in,
	input wire logic [1:0]                     trig_out,
	input wire logic                           irq_out
);
	logic [11:0] w_r;
	logic        um;
	logic        rdi;

	// ==========================================================
	// helpers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			w_r <= 12'h000;
		else
			w_r <= trig_out[0] ? w_r + 12'h001 : 12'h000;
	end
	assign um = paddr[7] ? (paddr != `PCT_REG_INTAXIS) : (paddr[5:0] > `PCT_REG_INTSTS || paddr[1:0] != 2'h0);
	assign rdi = psel && !pwrite && !paddr[7] && paddr[5:0] == `PCT_REG_INTSTS;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ==========================================================
	// properties
	sequence s_rd;
		psel && !penable && !pwrite;
	endsequence
	property p_ready;
		pready;
	endproperty
	property p_err;
		psel && penable |-> pslverr == um;
	endproperty
	property p_unm;
		s_rd ##0 um |=> prdata == 32'h0;
	endproperty
	property p_axis;
		s_rd ##0 paddr == `PCT_REG_INTAXIS |=> prdata[31:2] == 30'h0 && (prdata[1:0] != 2'h0) == $past(irq_out);
	endproperty
	property p_sts;
		s_rd ##0 paddr == {2'h0, `PCT_REG_STS} |=> prdata[`PCT_STS_PULSE] == $past(trig_out[0]);
	endproperty
	property p_stand;
		psel && penable |=> $stable(prdata);
	endproperty
	property p_wide;
		$fell(trig_out[0]) |-> w_r == `PCT_PULSE_CYC;
	endproperty
	property p_short;
		trig_out[0] |-> w_r < `PCT_PULSE_CYC;
	endproperty
	property p_irqfell;
		$fell(irq_out) |-> $past(rdi) || $past(rdi, 2);
	endproperty

	a_ready: assert property (p_ready) else $error("pready low");
	a_err: assert property (p_err) else $error("pslverr wrong");
	a_unm: assert property (p_unm) else $error("unmapped read not zero");
	a_axis: assert property (p_axis) else $error("axis flags disagree with irq");
	a_sts: assert property (p_sts) else $error("pulse status wrong");
	a_stand: assert property (p_stand) else $error("read data moved");
	a_wide: assert property (p_wide) else $error("pulse width wrong");
	a_short: assert property (p_short) else $error("pulse too long");
	a_irqfell: assert property (p_irqfell) else $error("irq dropped without status read");
endmodule

`default_nettype wire

// >>> tb_top.sv
// self-checking bench for the position compare block
// assumes pct_map.svh, pct_pkg, the design, checker and encoder model compiled first
`include "pct_map.svh"
`timescale 1ns/1ns
`default_nettype none

module tb_top;
	logic        pclk, presetn, psel, penable, pwrite, up, dn, e;
	logic [7:0]  paddr;
	logic [31:0] pwdata, q;
	logic [1:0]  hd;
	logic [11:0] cs1;
	wire  [31:0] prdata;
	wire         pready, pslverr, irq_out, ea, eb;
	wire  [1:0]  trig_out;
	wire pct_pkg::pct_axis_in_type [1:0] ain = {{2'h0, hd[1], cs1}, {ea, eb, hd[0], 12'h000}};
	int          errors, tests_run, cyc;

	pct_top u_pct_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.axis_in(ain), .trig_out(trig_out), .irq_out(irq_out));
	pct_enc_model u_pct_enc_model (.pclk(pclk), .up(up), .dn(dn), .ea(ea), .eb(eb));

	// ==========================================================
	// helpers
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	task end_of_test;
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 60000) begin
			errors++;
			end_of_test;
		end
	end
	task chk(input logic [31:0] g, x);
		tests_run++;
		if (g !== x) begin
			$display("BAD t=%0t got=%h exp=%h", $time, g, x);
			errors++;
		end
	endtask
	function logic [7:0] ra(input logic ax, input logic [5:0] o);
		return {1'b0, ax, o};
	endfunction
	function logic [31:0] md(input logic t, i, h, input logic [1:0] s, r);
		return {25'h0, t, i, h, s, r};
	endfunction
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task tk(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask
	task pulse(input int ax);
		int n;
		n = 0;
		while (trig_out[ax] !== 1'b1 && n < 50) begin
			tk(1);
			n++;
		end
		n = 0;
		while (trig_out[ax] === 1'b1 && n < 3000) begin
			tk(1);
			n++;
		end
		chk(32'(n), `PCT_PULSE_CYC);
	endtask

	// ==========================================================
	// scenarios
	task t_direct;
		for (int i = 0; i < 3; i++) begin
			apb(1, ra(0, `PCT_REG_MODE), md(0, i == 0, 0, `PCT_SRC_C1, 2'(i)));
			apb(1, ra(0, `PCT_REG_CNT), 32'(100 - 50 * i));
			apb(1, ra(0, `PCT_REG_DATA), 32'h32);
			pulse(0);
			chk(irq_out, i == 0);
			tk(20);
			chk(trig_out[0], 0);
			if (i == 0) begin
				apb(0, ra(0, `PCT_REG_INTSTS), 0);
				chk(q, 32'h1 << `PCT_CAUSE_CMP);
				tk(1);
				chk(irq_out, 0);
			end
		end
	endtask
	task t_src;
		apb(1, ra(1, `PCT_REG_MODE), md(0, 0, 0, `PCT_SRC_C2, `PCT_REL_EQ));
		apb(1, ra(1, `PCT_REG_CNT), 0);
		apb(1, ra(0, `PCT_REG_CNT), 32'h4d);
		apb(1, ra(1, `PCT_REG_DATA), 32'h4d);
		pulse(1);
		apb(1, ra(1, `PCT_REG_MODE), md(0, 0, 0, `PCT_SRC_BOTH, `PCT_REL_EQ));
		apb(1, ra(1, `PCT_REG_DATA), 32'h4d);
		tk(20);
		chk(trig_out[1], 0);
		apb(1, ra(1, `PCT_REG_CNT), 32'h4d);
		pulse(1);
	endtask
	task t_table;
		apb(1, ra(0, `PCT_REG_TSIZE), 3);
		apb(1, ra(0, `PCT_REG_TADDR), 0);
		for (int k = 1; k < 4; k++)
			apb(1, ra(0, `PCT_REG_TWDATA), 32'(10 * k));
		apb(1, ra(0, `PCT_REG_CNT), 0);
		apb(1, ra(0, `PCT_REG_MODE), md(1, 0, 0, `PCT_SRC_C1, `PCT_REL_EQ));
		for (int k = 1; k < 4; k++) begin
			apb(1, ra(0, `PCT_REG_CNT), 32'(10 * k));
			pulse(0);
		end
		apb(0, ra(0, `PCT_REG_STS), 0);
		chk(q[`PCT_STS_DONE], 1);
		apb(1, ra(0, `PCT_REG_CNT), 32'h1e);
		tk(20);
		chk(trig_out[0], 0);
	endtask
	task step(input logic u, input int n);
		repeat (n) begin
			@(posedge pclk);
			up <= u;
			dn <= !u;
			@(posedge pclk);
			up <= 1'b0;
			dn <= 1'b0;
		end
		tk(4);
	endtask
	task t_quad;
		apb(1, ra(0, `PCT_REG_CNT), 0);
		step(1, 5);
		apb(0, ra(0, `PCT_REG_CNT), 0);
		chk(q, 5);
		step(0, 7);
		apb(0, ra(0, `PCT_REG_CNT), 0);
		chk(q, 32'hfffffffe);
	endtask
	task t_home;
		apb(1, ra(0, `PCT_REG_MODE), md(0, 0, 1, `PCT_SRC_C1, `PCT_REL_GT));
		apb(1, ra(0, `PCT_REG_CNT), 32'h7b);
		hd <= 2'h1;
		tk(3);
		hd <= 2'h0;
		apb(0, ra(0, `PCT_REG_CNT), 0);
		chk(q, 0);
	endtask
	task cz(input logic [11:0] v);
		@(posedge pclk);
		cs1 <= v;
		@(posedge pclk);
		cs1 <= 12'h000;
		tk(2);
	endtask
	task t_cause;
		apb(1, ra(1, `PCT_REG_FACTOR), 1);
		cz(12'h002);
		chk(irq_out, 0);
		cz(12'h001);
		chk(irq_out, 1);
		apb(0, `PCT_REG_INTAXIS, 0);
		chk(q, 2);
		apb(0, ra(1, `PCT_REG_INTSTS), 0);
		chk(q, 1);
		apb(0, 8'h3c, 0);
		chk(q, 0);
		chk(e, 1);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		{psel, penable, pwrite, up, dn, paddr, pwdata, hd, cs1} = '0;
		errors = 0;
		tests_run = 0;
		cyc = 0;
		presetn = 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_direct;
		t_src;
		t_table;
		t_quad;
		t_home;
		t_cause;
		end_of_test;
	end
endmodule

bind pct_top pct_top_properties u_pct_top_properties (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .axis_in(axis_in), .trig_out(trig_out), .irq_out(irq_out));

`default_nettype wire
